/* File: core/frc_unit.sv */
// Register command unit of a serial NOR flash: frames, decodes and executes
// register commands arriving on the serial lanes.
// Assumes SCLK, CS_N and DQ_IN come from pins (synchronised here) and that the
// serial clock runs well below a quarter of CLOCK.
//
// Functional notes
// - NV config read: 16 bits, then zeros
// - NV config reserved fields read as 1
// - Volatile config reads repeat same byte
// - One, two or four lanes per protocol
// - Chip select ends a read anywhere
// - Write executes on chip select rising edge
// - Status write touches only bits 7:2
// - Write-in-progress high during self-timed write
// - Status/NV writes clear write enable latch
// - NV config travels low byte first
// - Misframed write discarded, latch stays set; in extended mode an overrun of a multiple of 10 bits (NV: 18) executes
// - Volatile writes keep reserved bits
// - Lock commands take three address bytes
// - Lock read shifts out on falling edge
// - Lock read rejected while array busy
// - Lock byte bits 7:2 read zero
// - Write-locked sector refuses program/erase
// - Lock-down freezes sector lock bits
// - Lock write: address, one byte, immediate
// - Lock write clears latch, allowed in suspend
// - Clear flags resets three error flags
// - Register commands carry no address/dummy
// - Lock commands: address then data directly
`timescale 1ns/1ps
module frc_unit
  import frc_pkg::*;
#(
  parameter int SECTORS = 128,
  parameter int SEC_W = 7
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic [3:0] DQ_IN,
  output logic [3:0] DQ_OUT,
  output logic [3:0] DQ_OE,
  input wire logic [1:0] PROTOCOL_SEL,
  input wire logic ARRAY_BUSY,
  input wire logic [SEC_W-1:0] PE_SECTOR,
  input wire logic [2:0] FLAG_ERR_SET,
  output logic PE_DENY,
  output logic WIP_FLAG,
  output logic WEL_FLAG
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic sclk_s1, sclk_s2, sclk_s3; // Serial clock pipeline
  logic cs_s1, cs_s2, cs_s3; // Chip select pipeline
  logic [3:0] dq_s1, dq_s2; // Lane inputs, same lag as the clock

  // Two flops per pin; the third stage only serves edge detection
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      dq_s1 <= 4'h0;
      dq_s2 <= 4'h0;
    end else begin
      {sclk_s1, sclk_s2, sclk_s3} <= {SCLK, sclk_s1, sclk_s2};
      {cs_s1, cs_s2, cs_s3} <= {CS_N, cs_s1, cs_s2};
      dq_s1 <= DQ_IN;
      dq_s2 <= dq_s1;
    end
  end

  wire sel = ~cs_s2; // Frame active
  wire rise = sel & sclk_s2 & ~sclk_s3; // Input sampling edge
  wire fall = sel & ~sclk_s2 & sclk_s3; // Output shifting edge
  wire cs_rise = cs_s2 & ~cs_s3; // End of frame

  // ----------------------------------------------------------------
  // State and register storage
  // ----------------------------------------------------------------
  frc_state_t st_reg; // Frame phase
  frc_cmd_t cur_reg; // Command of this frame
  logic [5:0] cnt_reg; // Bits taken in this phase
  logic [31:0] in_reg; // Input shift register
  logic [15:0] out_reg; // Output shift register
  logic [4:0] ocnt_reg; // Bits sent, saturating, for the zero tail
  logic [SEC_W-1:0] sec_reg; // Sector chosen by the address phase
  logic [7:2] sr_reg; // Writable status bits
  logic [15:0] nvcr_reg; // Nonvolatile configuration
  logic [7:0] vcr_reg, evcr_reg; // Volatile configurations
  logic [2:0] flag_reg; // Erase, program, protection errors
  logic [1:0] lock_mem [SECTORS]; // Per-sector lock-down and write-lock
  logic [15:0] tmr_reg; // Self-timed write countdown
  logic wel_reg, wip_reg; // Write enable latch, write in progress

  // ----------------------------------------------------------------
  // Lane width and shifting
  // ----------------------------------------------------------------
  wire quad = (PROTOCOL_SEL == PR_QUAD);
  wire dual = (PROTOCOL_SEL == PR_DUAL);
  wire [5:0] lanes = quad ? 6'h04 : (dual ? 6'h02 : 6'h01);
  wire [31:0] in_sh = quad ? {in_reg[27:0], dq_s2} :
    (dual ? {in_reg[29:0], dq_s2[1:0]} : {in_reg[30:0], dq_s2[0]});
  wire [5:0] cnt_inc = cnt_reg + lanes;
  // Repeating reads rotate a doubled byte; the NV read shifts zeros in
  wire [15:0] out_rot = quad ? {out_reg[11:0], out_reg[15:12]} :
    (dual ? {out_reg[13:0], out_reg[15:14]} : {out_reg[14:0], out_reg[15]});
  wire [15:0] out_zero = quad ? {out_reg[11:0], 4'h0} :
    (dual ? {out_reg[13:0], 2'h0} : {out_reg[14:0], 1'b0});
  // Extended drives the second lane only, dual two lanes, quad four
  wire [3:0] out_top = quad ? out_reg[15:12] :
    (dual ? {2'h0, out_reg[15:14]} : {2'h0, out_reg[15], 1'b0});
  wire [3:0] oe_mask = quad ? 4'hf : (dual ? 4'h3 : 4'h2);

  // ----------------------------------------------------------------
  // Command decode and read data selection
  // ----------------------------------------------------------------
  wire frc_cmd_t dec = frc_decode(in_sh[7:0]);
  wire cmd_done = rise && (st_reg == ST_CMD) && (cnt_inc == CMD_BITS);
  wire addr_done = rise && (st_reg == ST_ADDR) && (cnt_inc == ADDR_BITS);
  wire [SEC_W-1:0] sec_now = in_sh[SEC_W+15:16]; // 64 KB sector index
  wire [1:0] lk_now = lock_mem[sec_now];
  wire [1:0] lk_sel = lock_mem[sec_reg];
  wire wr_ok = wel_reg && !wip_reg;
  wire lk_rd_ok = !ARRAY_BUSY && !wip_reg;
  wire [7:0] status_byte = {sr_reg, wel_reg, wip_reg};
  wire [7:0] flag_byte = {~wip_reg, 1'b0, flag_reg[2], flag_reg[1], 2'h0, flag_reg[0], 1'b0};
  wire [7:0] rd_byte = (dec.tgt == TG_SR) ? status_byte :
    (dec.tgt == TG_FS) ? flag_byte :
    (dec.tgt == TG_VC) ? vcr_reg : evcr_reg;
  // NV register leaves low byte first with reserved bits forced high
  wire [15:0] nv_out = {nvcr_reg[7:0] | NVCR_RSVD[7:0],
    nvcr_reg[15:8] | NVCR_RSVD[15:8]};
  wire [15:0] load_cmd = (dec.tgt == TG_NV) ? nv_out : {rd_byte, rd_byte};
  wire [15:0] load_lock = {6'h00, lk_now, 6'h00, lk_now};

  // ----------------------------------------------------------------
  // Write execution at end of frame
  // ----------------------------------------------------------------
  // An exact data length executes, and in extended mode that length plus a multiple of 10 (byte) or 18 (NV) bits; other boundaries discard
  wire exec = cs_rise && (st_reg == ST_WDATA) && (cnt_reg == cur_reg.wbits);
  wire exec_sr = exec && (cur_reg.tgt == TG_SR);
  wire exec_nv = exec && (cur_reg.tgt == TG_NV);
  wire exec_vc = exec && (cur_reg.tgt == TG_VC);
  wire exec_ev = exec && (cur_reg.tgt == TG_EV);
  wire exec_lk = exec && (cur_reg.tgt == TG_LK);
  wire do_wren = cmd_done && (in_sh[7:0] == OP_WR_ENABLE);
  wire do_clr = cmd_done && (in_sh[7:0] == OP_CLR_FLAGS);
  wire [15:0] nv_in = {in_reg[7:0], in_reg[15:8]};

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Sequencer steps on sampling edges; chip select high always restarts it
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg <= ST_CMD;
      cnt_reg <= 6'h00;
      in_reg <= 32'h0;
      cur_reg <= '0;
      sec_reg <= '0;
    end else if (!sel) begin
      st_reg <= ST_CMD;
      cnt_reg <= 6'h00;
    end else if (rise) begin
      in_reg <= in_sh;
      cnt_reg <= cnt_inc;
      unique case (st_reg)
        ST_CMD: begin
          if (cmd_done) begin
            cur_reg <= dec;
            cnt_reg <= 6'h00;
            if (dec.addr) begin
              st_reg <= (dec.wr && !wr_ok) ? ST_HOLD : ST_ADDR;
            end else if (dec.rd) begin
              st_reg <= ST_RDATA;
            end else if (dec.wr && wr_ok) begin
              st_reg <= ST_WDATA;
            end else begin
              st_reg <= ST_HOLD;
            end
          end
        end
        ST_ADDR: begin
          if (addr_done) begin
            sec_reg <= sec_now;
            cnt_reg <= 6'h00;
            if (cur_reg.rd) begin
              st_reg <= lk_rd_ok ? ST_RDATA : ST_HOLD;
            end else begin
              st_reg <= ST_WDATA;
            end
          end
        end
        // Extra bits set the count to 3f; dual and quad never return to the length, extended wraps to 0 and can reach it again
        ST_WDATA: cnt_reg <= (cnt_inc > cur_reg.wbits) ? 6'h3f : cnt_inc;
        ST_RDATA: cnt_reg <= 6'h00;
        ST_HOLD: cnt_reg <= 6'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output shifter and lane drivers
  // ----------------------------------------------------------------
  // Load on the last command/address edge; present and shift on falling edges
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      out_reg <= 16'h0;
      ocnt_reg <= 5'h00;
      DQ_OUT <= 4'h0;
      DQ_OE <= 4'h0;
    end else if (!sel || st_reg == ST_HOLD) begin
      DQ_OE <= 4'h0;
      DQ_OUT <= 4'h0;
    end else if (cmd_done && dec.rd && !dec.addr) begin
      out_reg <= load_cmd;
      ocnt_reg <= 5'h00;
    end else if (addr_done) begin
      out_reg <= load_lock;
      ocnt_reg <= 5'h00;
    end else if (fall && st_reg == ST_RDATA) begin
      DQ_OUT <= out_top;
      DQ_OE <= oe_mask;
      out_reg <= cur_reg.rep ? out_rot : out_zero;
      ocnt_reg <= (ocnt_reg >= NV_OUT_BITS) ? NV_OUT_BITS : ocnt_reg + 5'(lanes);
    end
  end

  // ----------------------------------------------------------------
  // Registers, latch, flags and self-timed write
  // ----------------------------------------------------------------
  // Status, configuration, latch and timer updates
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sr_reg <= SR_RESET[7:2];
      nvcr_reg <= NVCR_RESET;
      vcr_reg <= VCR_RESET;
      evcr_reg <= EVCR_RESET;
      wel_reg <= 1'b0;
      wip_reg <= 1'b0;
      tmr_reg <= 16'h0;
    end else begin
      if (exec_sr) begin
        sr_reg <= in_reg[7:2];
      end
      if (exec_nv) begin
        nvcr_reg <= nv_in;
      end
      if (exec_vc) begin
        vcr_reg <= (in_reg[7:0] & ~VCR_RSVD) | (vcr_reg & VCR_RSVD);
      end
      if (exec_ev) begin
        evcr_reg <= (in_reg[7:0] & ~EVCR_RSVD) | (evcr_reg & EVCR_RSVD);
      end
      // Any executed write drops the latch; discarded ones leave it set
      if (exec) begin
        wel_reg <= 1'b0;
      end else if (do_wren) begin
        wel_reg <= 1'b1;
      end
      if (exec_sr || exec_nv) begin
        wip_reg <= 1'b1;
        tmr_reg <= exec_sr ? STATUS_WRITE_CYC : NV_CONFIG_WRITE_CYC;
      end else if (tmr_reg != 16'h0) begin
        tmr_reg <= tmr_reg - 16'h1;
        wip_reg <= (tmr_reg != 16'h1);
      end
    end
  end

  // Error flags: a new error in the clearing cycle still sets its flag
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      flag_reg <= 3'h0;
    end else begin
      flag_reg <= (flag_reg & {3{~do_clr}}) | FLAG_ERR_SET;
    end
  end

  // Sector lock bits: volatile, cleared at power-up, frozen by lock-down
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < SECTORS; i++) begin
        lock_mem[i] <= 2'h0;
      end
    end else if (exec_lk && !lk_sel[1]) begin
      lock_mem[sec_reg] <= in_reg[1:0];
    end
  end

  // Program/erase veto and flag outputs
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PE_DENY <= 1'b0;
      WIP_FLAG <= 1'b0;
      WEL_FLAG <= 1'b0;
    end else begin
      PE_DENY <= lock_mem[PE_SECTOR][0];
      WIP_FLAG <= wip_reg;
      WEL_FLAG <= wel_reg;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire nv_tail = (st_reg == ST_RDATA) && (cur_reg.tgt == TG_NV) && fall
    && (ocnt_reg >= NV_OUT_BITS);
  wire [1:0] pe_lock = lock_mem[PE_SECTOR];
  sequence s_sr_start;
    exec_sr ##1 (wip_reg && !wel_reg);
  endsequence
  sequence s_busy_hold;
    wip_reg [*8];
  endsequence

  a_nv_zero_tail: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    nv_tail |=> (DQ_OUT == 4'h0))
    else $error("NV read tail not zero");
  a_status_timed: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_sr_start |-> s_busy_hold)
    else $error("status write busy window too short");
  a_status_bits: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    exec_sr |=> (status_byte[7:2] == $past(in_reg[7:2])) && !wel_reg)
    else $error("status write result wrong");
  a_abort_keeps: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (cs_rise && st_reg == ST_WDATA && cnt_reg != cur_reg.wbits && wel_reg && !do_wren)
    |=> wel_reg && $stable(nvcr_reg))
    else $error("misframed write took effect");
  a_lockdown_frozen: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (exec_lk && lk_sel[1]) |=> $stable(lk_sel))
    else $error("locked-down sector changed");
  a_pe_refuse: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ##1 (PE_DENY == $past(pe_lock[0])))
    else $error("program/erase veto wrong");
  a_lock_reject: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (addr_done && cur_reg.rd && !lk_rd_ok) |=> (st_reg == ST_HOLD) ##1 (DQ_OE == 4'h0))
    else $error("lock read not rejected");
  a_no_latch_write: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (cmd_done && dec.wr && !wel_reg) |=> (st_reg == ST_HOLD))
    else $error("write accepted without latch");
  a_flags_clear: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (do_clr && FLAG_ERR_SET == 3'h0) |=> (flag_reg == 3'h0))
    else $error("flags not cleared");
  a_lock_ro_bits: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    addr_done |=> (out_reg[15:10] == 6'h00))
    else $error("lock byte upper bits not zero");

endmodule // frc_unit

/* File: core/frc_pkg.sv */
// Shared constants, types and command decode for the flash register command unit.
// Assumes a single 125 MHz system clock; serial pins are sampled by that clock.
package frc_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_RD_LOCK = 8'he8;
  localparam logic [7:0] OP_WR_LOCK = 8'he5;
  localparam logic [7:0] OP_RD_FLAGS = 8'h70;
  localparam logic [7:0] OP_CLR_FLAGS = 8'h50;
  localparam logic [7:0] OP_RD_NVCFG = 8'hb5;
  localparam logic [7:0] OP_WR_NVCFG = 8'hb1;
  localparam logic [7:0] OP_RD_VCFG = 8'h85;
  localparam logic [7:0] OP_WR_VCFG = 8'h81;
  localparam logic [7:0] OP_RD_EVCFG = 8'h65;
  localparam logic [7:0] OP_WR_EVCFG = 8'h61;

  // ----------------------------------------------------------------
  // Phase lengths in bits
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] NV_BITS = 6'h10;
  localparam logic [4:0] NV_OUT_BITS = 5'h10;

  // ----------------------------------------------------------------
  // Reset values and reserved masks (reserved bits read as 1 / are kept)
  // ----------------------------------------------------------------
  localparam logic [7:0] SR_RESET = 8'h00;
  localparam logic [15:0] NVCR_RESET = 16'hffff;
  localparam logic [7:0] VCR_RESET = 8'hfb;
  localparam logic [7:0] EVCR_RESET = 8'hdf;
  localparam logic [15:0] NVCR_RSVD = 16'h0010;
  localparam logic [7:0] VCR_RSVD = 8'h04;
  localparam logic [7:0] EVCR_RSVD = 8'h10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int STATUS_WRITE_TIME_NS = 1000;
  localparam int NV_CONFIG_WRITE_TIME_NS = 2000;
  localparam logic [15:0] STATUS_WRITE_CYC =
    16'((STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] NV_CONFIG_WRITE_CYC =
    16'((NV_CONFIG_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_CMD = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_WDATA = 5'b00100,
    ST_RDATA = 5'b01000,
    ST_HOLD = 5'b10000
  } frc_state_t;

  localparam logic [1:0] PR_EXT = 2'h0;
  localparam logic [1:0] PR_DUAL = 2'h1;
  localparam logic [1:0] PR_QUAD = 2'h2;

  localparam logic [2:0] TG_NONE = 3'h0;
  localparam logic [2:0] TG_SR = 3'h1;
  localparam logic [2:0] TG_FS = 3'h2;
  localparam logic [2:0] TG_NV = 3'h3;
  localparam logic [2:0] TG_VC = 3'h4;
  localparam logic [2:0] TG_EV = 3'h5;
  localparam logic [2:0] TG_LK = 3'h6;
  localparam logic [2:0] TG_CTL = 3'h7;

  // Decoded command: what it touches and how its frame is shaped
  typedef struct packed {
    logic rd;
    logic wr;
    logic addr;
    logic rep;
    logic [5:0] wbits;
    logic [2:0] tgt;
  } frc_cmd_t;

  function automatic frc_cmd_t frc_decode(input logic [7:0] op);
    frc_cmd_t c;
    c = '{rd: 1'b0, wr: 1'b0, addr: 1'b0, rep: 1'b0, wbits: 6'h00, tgt: TG_NONE};
    case (op)
      OP_WR_ENABLE, OP_CLR_FLAGS: c.tgt = TG_CTL;
      OP_RD_STATUS: c = '{1'b1, 1'b0, 1'b0, 1'b1, 6'h00, TG_SR};
      OP_RD_FLAGS: c = '{1'b1, 1'b0, 1'b0, 1'b1, 6'h00, TG_FS};
      OP_RD_NVCFG: c = '{1'b1, 1'b0, 1'b0, 1'b0, 6'h00, TG_NV};
      OP_RD_VCFG: c = '{1'b1, 1'b0, 1'b0, 1'b1, 6'h00, TG_VC};
      OP_RD_EVCFG: c = '{1'b1, 1'b0, 1'b0, 1'b1, 6'h00, TG_EV};
      OP_RD_LOCK: c = '{1'b1, 1'b0, 1'b1, 1'b1, 6'h00, TG_LK};
      OP_WR_STATUS: c = '{1'b0, 1'b1, 1'b0, 1'b0, BYTE_BITS, TG_SR};
      OP_WR_NVCFG: c = '{1'b0, 1'b1, 1'b0, 1'b0, NV_BITS, TG_NV};
      OP_WR_VCFG: c = '{1'b0, 1'b1, 1'b0, 1'b0, BYTE_BITS, TG_VC};
      OP_WR_EVCFG: c = '{1'b0, 1'b1, 1'b0, 1'b0, BYTE_BITS, TG_EV};
      OP_WR_LOCK: c = '{1'b0, 1'b1, 1'b1, 1'b0, BYTE_BITS, TG_LK};
      default: c.tgt = TG_NONE;
    endcase
    return c;
  endfunction

endpackage

/* File: verification/frc_host.sv */
// Host controller model: frames register commands on the serial lanes.
// Assumes one caller at a time; SCLK rests low and lanes are shared wires.
`timescale 1ns/1ps
module frc_host (
  input wire logic [1:0] PROTOCOL_SEL,
  input wire logic [3:0] DQ_OUT,
  input wire logic [3:0] DQ_OE,
  output logic SCLK,
  output logic CS_N,
  output logic [3:0] DQ_IN
);
  logic [3:0] drv = 4'h5; // Host drive on the lanes
  logic [3:0] oe_seen = 4'h0; // Lanes the device drove in this frame
  int w; // Lanes per serial clock
  // Shared wire: a lane the device enables carries the device's level
  assign DQ_IN = (DQ_OE & DQ_OUT) | (~DQ_OE & drv);
  assign w = (PROTOCOL_SEL == 2'h2) ? 4 : ((PROTOCOL_SEL == 2'h1) ? 2 : 1);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
  end
  // One byte, MSB first, higher lane carries the higher bit
  task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
    logic [3:0] q;
    logic [7:0] s;
    s = b;
    r = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      drv = 4'(s >> (8 - w));
      s = 8'(s << w);
      #32 SCLK = 1'b1;
      #32 q = DQ_OUT;
      oe_seen = oe_seen | DQ_OE;
      SCLK = 1'b0;
      r = 8'((r << w) | ((w == 1) ? 8'(q[1]) : 8'(q & 4'((1 << w) - 1))));
    end
  endtask
  // Whole frame: code, address and data straight after, no dummies
  task automatic frame(input logic [7:0] op, input int nin, input logic [31:0] din,
                       input int nout, output logic [23:0] dout);
    logic [7:0] r;
    oe_seen = 4'h0;
    #3 CS_N = 1'b0;
    #64;
    xbyte(op, r);
    for (int i = nin - 1; i >= 0; i--) xbyte(din[i * 8 +: 8], r);
    dout = 24'h0;
    for (int i = 0; i < nout; i++) begin
      xbyte(8'h00, r);
      dout = {dout[15:0], r};
    end
    // Raise select right after the last bit, released lanes flip
    #32 CS_N = 1'b1;
    drv = ~drv;
    #128;
  endtask
endmodule // frc_host

/* File: verification/frc_unit_tb.sv */
// Self-checking bench for the register command unit.
// Assumes the host model drives the link at a 64 ns serial period.
`timescale 1ns/1ps
module frc_unit_tb
  import frc_pkg::*;
;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] prot = PR_EXT;
  logic busy = 1'b0;
  logic [6:0] pe_sec = 7'h00;
  logic [2:0] err_set = 3'h0;
  logic sclk, cs_n, pe_deny, wip_flag, wel_flag;
  logic [3:0] dq_in, dq_out, dq_oe;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] rnd = 8'h47; // Fixed seed
  logic [15:0] nv; // Model of the nonvolatile register
  logic [6:0] sec; // Sector under test
  logic [23:0] d;
  logic [1:0] pr[3] = '{PR_EXT, PR_DUAL, PR_QUAD};
  logic [3:0] om[3] = '{4'h2, 4'h3, 4'hf};
  always #4 clock = ~clock;
  frc_unit uut (.CLOCK(clock), .ARST_N(arst_n), .SCLK(sclk), .CS_N(cs_n), .DQ_IN(dq_in),
    .DQ_OUT(dq_out), .DQ_OE(dq_oe), .PROTOCOL_SEL(prot), .ARRAY_BUSY(busy),
    .PE_SECTOR(pe_sec), .FLAG_ERR_SET(err_set), .PE_DENY(pe_deny), .WIP_FLAG(wip_flag),
    .WEL_FLAG(wel_flag));
  frc_host host (.PROTOCOL_SEL(prot), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .SCLK(sclk),
    .CS_N(cs_n), .DQ_IN(dq_in));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input string what, input logic [7:0] op, input int nin,
                      input logic [31:0] din, input int nout, input logic [23:0] exp);
    host.frame(op, nin, din, nout, d);
    chk(what, d, exp);
  endtask
  // Write enable first, then the write itself
  task automatic wr(input logic [7:0] op, input int n, input logic [31:0] din);
    host.frame(OP_WR_ENABLE, 0, 0, 0, d);
    chk("wel", wel_flag, 1);
    host.frame(op, n, din, 0, d);
  endtask
  task automatic waitwip;
    for (int i = 0; i < 400 && wip_flag !== 1'b0; i++) @(posedge clock);
    chk("wipclr", wip_flag, 0);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    rchk("sr0", OP_RD_STATUS, 0, 0, 1, 0);
    rchk("nv0", OP_RD_NVCFG, 0, 0, 3, 24'hffff00);
    rchk("vc0", OP_RD_VCFG, 0, 0, 3, 24'hfbfbfb);
    rchk("ev0", OP_RD_EVCFG, 0, 0, 2, 16'hdfdf);
    host.frame(OP_WR_STATUS, 1, 32'hfc, 0, d);
    rchk("nowel", OP_RD_STATUS, 0, 0, 1, 0);
    $display("test resets done");
    rnd = lfsr(rnd);
    wr(OP_WR_STATUS, 1, rnd);
    chk("wip1", wip_flag, 1);
    chk("wel0", wel_flag, 0);
    waitwip();
    rchk("sr", OP_RD_STATUS, 0, 0, 1, rnd & 8'hfc);
    rnd = lfsr(rnd);
    nv = {~rnd, rnd} | NVCR_RSVD;
    wr(OP_WR_NVCFG, 2, {rnd, ~rnd});
    chk("wipn", wip_flag, 1);
    waitwip();
    rchk("nv", OP_RD_NVCFG, 0, 0, 3, {nv[7:0], nv[15:8], 8'h00});
    wr(OP_WR_NVCFG, 1, 8'h00);
    chk("welkeep", wel_flag, 1);
    chk("wipkeep", wip_flag, 0);
    rchk("nvkeep", OP_RD_NVCFG, 0, 0, 2, {nv[7:0], nv[15:8]});
    rchk("fs0", OP_RD_FLAGS, 0, 0, 1, 8'h80);
    wr(OP_WR_VCFG, 1, 8'hff);
    wr(OP_WR_EVCFG, 1, 8'h00);
    rchk("ev", OP_RD_EVCFG, 0, 0, 1, 8'h10);
    $display("test writes done");
    // Same byte on every protocol, on the right lanes
    for (int i = 0; i < 3; i++) begin
      @(posedge clock) prot <= pr[i];
      rchk("vcp", OP_RD_VCFG, 0, 0, 2, 16'hfbfb);
      chk("oe", host.oe_seen, om[i]);
    end
    @(posedge clock) prot <= PR_EXT;
    rnd = lfsr(rnd);
    sec = rnd[6:0];
    wr(OP_WR_LOCK, 4, {1'b0, sec, 16'h0000, 8'hfd});
    chk("welk", wel_flag, 0);
    rchk("lk", OP_RD_LOCK, 3, {1'b0, sec, 16'h0}, 2, 16'h0101);
    @(posedge clock) pe_sec <= sec;
    repeat (3) @(posedge clock);
    chk("deny", pe_deny, 1);
    @(posedge clock) pe_sec <= sec + 7'h1;
    repeat (3) @(posedge clock);
    chk("allow", pe_deny, 0);
    @(posedge clock) busy <= 1'b1;
    host.frame(OP_RD_LOCK, 3, {1'b0, sec, 16'h0}, 1, d);
    chk("reject", host.oe_seen, 0);
    wr(OP_WR_LOCK, 4, {1'b0, sec, 16'h0000, 8'h03});
    @(posedge clock) busy <= 1'b0;
    rchk("lkd", OP_RD_LOCK, 3, {1'b0, sec, 16'h0}, 1, 8'h03);
    wr(OP_WR_LOCK, 4, {1'b0, sec, 16'h0000, 8'h00});
    rchk("lkd2", OP_RD_LOCK, 3, {1'b0, sec, 16'h0}, 1, 8'h03);
    $display("test locks done");
    @(posedge clock) err_set <= 3'h7;
    @(posedge clock) err_set <= 3'h0;
    rchk("fs", OP_RD_FLAGS, 0, 0, 1, 8'hb2);
    host.frame(OP_CLR_FLAGS, 0, 0, 0, d);
    rchk("fsclr", OP_RD_FLAGS, 0, 0, 1, 8'h80);
    $display("test flags done");
    final_report();
  end
endmodule // frc_unit_tb
